// ### common/upptc_pkg.sv
package upptc_pkg;

  // ------------------------------------------------------------
  // register map: index as printed, byte address is index * 4
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_SLEEP = 10'h053;
  localparam logic [9:0] IDX_BIST = 10'h054;
  localparam logic [9:0] IDX_TRIM_LO = 10'h055;
  localparam logic [9:0] IDX_TRIM_HI = 10'h056;
  localparam logic [9:0] IDX_HS_TEST = 10'h057;
  localparam logic [9:0] IDX_INT_STS = 10'h060;
  localparam logic [9:0] IDX_INT_MSK = 10'h061;

  // ------------------------------------------------------------
  // reset values and writable-bit masks
  // ------------------------------------------------------------
  localparam logic [7:0] RST_SLEEP = 8'hF0;
  localparam logic [7:0] RST_BIST = 8'h00;
  localparam logic [7:0] RST_TRIM_LO = 8'hAA;
  localparam logic [7:0] RST_TRIM_HI = 8'h0A;
  localparam logic [7:0] RST_HS_TEST = 8'h00;
  localparam logic [7:0] RST_INT = 8'h00;
  localparam logic [7:0] WMSK_SLEEP = 8'hFF;
  localparam logic [7:0] WMSK_BIST = 8'hCF;
  localparam logic [7:0] WMSK_TRIM_LO = 8'hFF;
  localparam logic [7:0] WMSK_TRIM_HI = 8'h0F;
  localparam logic [7:0] WMSK_HS_TEST = 8'h3F;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int SLP_FAST_BIT = 7;
  localparam int SLP_LOCK_BIT = 6;
  localparam int BIST_FLAG_BIT = 4;
  localparam int BIST_RST_BIT = 3;
  localparam int INT_BIST_BIT = 0;
  localparam int INT_ACK_BIT = 1;
  localparam int INT_WAKE_LSB = 2;
  localparam int NPORT = 6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // controls carried to the phy
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] nsq_offset;
    logic loop_reset;
    logic [2:0] bist_pattern;
    logic [11:0] disc_trim;
    logic [5:0] hs_test;
  } upptc_phy_ctl_t;

endpackage : upptc_pkg

// ### verilog/upptc_regs.sv
// Notes on behaviour
// - fast sleep answer when idle or unconnected
// - lock source: circuit when set, else logic
// - per-port wake gating, ports 5,4 enabled
// - two-bit non-squelch offset drives phy, reset 00
// - match flag read-only; bit 3 holds loop reset
// - three pattern distortion bits, reset off
// - six disconnect trims, reset 10
// - six transmit self-test bits, reset zero
module upptc_regs
  import upptc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_req,
  input wire logic run_bit,
  input wire logic dev_connected,
  input wire logic sleep_ready,
  output logic sleep_ack,
  input wire logic pll_lock_circuit,
  input wire logic pll_lock_logic,
  output logic pll_lock_indication,
  input wire logic [NPORT-1:0] port_wake_evt,
  output logic [NPORT-1:0] port_wake_out,
  input wire logic bist_match,
  output upptc_phy_ctl_t phy_ctl,
  output logic irq
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx >= IDX_SLEEP && idx <= IDX_HS_TEST) ||
      idx == IDX_INT_STS || idx == IDX_INT_MSK;
  endfunction : is_mapped

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] sleep_ctl_r, sleep_ctl_nxt;
  logic [7:0] bist_ctl_r, bist_ctl_nxt;
  logic [7:0] trim_lo_r, trim_lo_nxt;
  logic [7:0] trim_hi_r, trim_hi_nxt;
  logic [7:0] hs_test_r, hs_test_nxt;
  logic [7:0] int_sts_r, int_sts_nxt;
  logic [7:0] int_msk_r, int_msk_nxt;
  logic aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt;
  logic [9:0] aw_idx_r, aw_idx_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic wen_r, wen_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic ack_r, ack_nxt;
  logic lock_r, lock_nxt;
  logic [NPORT-1:0] wake_out_r, wake_out_nxt;
  logic irq_r, irq_nxt;
  // two-stage synchronisers for pins from the analog side
  logic [NPORT+1:0] sync1_r, sync2_r;
  logic match_d_r;
  logic [NPORT+1:0] pins;
  logic lock_sync, match_sync;
  logic [NPORT-1:0] wake_sync;
  logic do_write;
  logic [7:0] events, rbyte;
  logic [9:0] ar_idx;

  assign pins = {bist_match, pll_lock_circuit, port_wake_evt};
  assign match_sync = sync2_r[NPORT+1];
  assign lock_sync = sync2_r[NPORT];
  assign wake_sync = sync2_r[NPORT-1:0];
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      match_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      match_d_r <= match_sync;
    end
  end

  // ------------------------------------------------------------
  // bus slave and register file
  // ------------------------------------------------------------
  always_comb
  begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    aw_idx_nxt = aw_idx_r;
    wbyte_nxt = wbyte_r;
    wen_nxt = wen_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    sleep_ctl_nxt = sleep_ctl_r;
    bist_ctl_nxt = bist_ctl_r;
    trim_lo_nxt = trim_lo_r;
    trim_hi_nxt = trim_hi_r;
    hs_test_nxt = hs_test_r;
    int_msk_nxt = int_msk_r;
    int_sts_nxt = int_sts_r;
    if (s_axi_awvalid && awready_r)
    begin
      aw_full_nxt = 1'b1;
      aw_idx_nxt = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && wready_r)
    begin
      w_full_nxt = 1'b1;
      wbyte_nxt = s_axi_wdata[7:0];
      wen_nxt = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_nxt = 1'b0;
    do_write = aw_full_r && w_full_r && !bvalid_r;
    if (do_write)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
    end
    // only lane 0 carries data; other lanes are dropped
    if (do_write && wen_r)
    begin
      case (aw_idx_r)
        IDX_SLEEP: sleep_ctl_nxt = wbyte_r & WMSK_SLEEP;
        IDX_BIST: bist_ctl_nxt = wbyte_r & WMSK_BIST;
        IDX_TRIM_LO: trim_lo_nxt = wbyte_r & WMSK_TRIM_LO;
        IDX_TRIM_HI: trim_hi_nxt = wbyte_r & WMSK_TRIM_HI;
        IDX_HS_TEST: hs_test_nxt = wbyte_r & WMSK_HS_TEST;
        IDX_INT_MSK: int_msk_nxt = wbyte_r;
        IDX_INT_STS: int_sts_nxt = int_sts_r & ~wbyte_r;
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    events = '0;
    events[INT_BIST_BIT] = match_sync && !match_d_r;
    events[INT_ACK_BIT] = ack_nxt && !ack_r;
    events[INT_WAKE_LSB +: NPORT] = wake_out_nxt;
    int_sts_nxt = int_sts_nxt | events;
    irq_nxt = |(int_sts_nxt & int_msk_nxt);
    awready_nxt = !aw_full_nxt && !bvalid_nxt;
    wready_nxt = !w_full_nxt && !bvalid_nxt;
  end

  always_comb
  begin
    case (ar_idx)
      IDX_SLEEP: rbyte = sleep_ctl_r;
      IDX_BIST: rbyte = bist_ctl_r | (8'(match_sync) << BIST_FLAG_BIT);
      IDX_TRIM_LO: rbyte = trim_lo_r;
      IDX_TRIM_HI: rbyte = trim_hi_r;
      IDX_HS_TEST: rbyte = hs_test_r;
      IDX_INT_STS: rbyte = int_sts_r;
      IDX_INT_MSK: rbyte = int_msk_r;
      default: rbyte = 8'h00;
    endcase
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_rvalid && s_axi_rready)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rbyte};
      rresp_nxt = is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    arready_nxt = !rvalid_nxt;
  end

  // ------------------------------------------------------------
  // sleep answer, lock select, wake gating
  // ------------------------------------------------------------
  always_comb
  begin
    // ready input is only bypassed when the bit allows it
    if (sleep_ctl_r[SLP_FAST_BIT] && (!run_bit || !dev_connected))
      ack_nxt = sleep_req;
    else
      ack_nxt = sleep_req && sleep_ready;
    lock_nxt = sleep_ctl_r[SLP_LOCK_BIT] ? lock_sync
      : pll_lock_logic;
    wake_out_nxt = wake_sync & sleep_ctl_r[NPORT-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_ctl_r <= RST_SLEEP;
      bist_ctl_r <= RST_BIST;
      trim_lo_r <= RST_TRIM_LO;
      trim_hi_r <= RST_TRIM_HI;
      hs_test_r <= RST_HS_TEST;
      int_sts_r <= RST_INT;
      int_msk_r <= RST_INT;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_idx_r <= '0;
      wbyte_r <= 8'h00;
      wen_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
      ack_r <= 1'b0;
      lock_r <= 1'b0;
      wake_out_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      sleep_ctl_r <= sleep_ctl_nxt;
      bist_ctl_r <= bist_ctl_nxt;
      trim_lo_r <= trim_lo_nxt;
      trim_hi_r <= trim_hi_nxt;
      hs_test_r <= hs_test_nxt;
      int_sts_r <= int_sts_nxt;
      int_msk_r <= int_msk_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      aw_idx_r <= aw_idx_nxt;
      wbyte_r <= wbyte_nxt;
      wen_r <= wen_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ack_r <= ack_nxt;
      lock_r <= lock_nxt;
      wake_out_r <= wake_out_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign sleep_ack = ack_r;
  assign pll_lock_indication = lock_r;
  assign port_wake_out = wake_out_r;
  assign irq = irq_r;
  assign phy_ctl.nsq_offset = bist_ctl_r[7:6];
  assign phy_ctl.loop_reset = bist_ctl_r[BIST_RST_BIT];
  assign phy_ctl.bist_pattern = bist_ctl_r[2:0];
  assign phy_ctl.disc_trim = {trim_hi_r[3:0], trim_lo_r};
  assign phy_ctl.hs_test = hs_test_r[5:0];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  fast_sleep_ack_a: assert property (
    sleep_req && sleep_ctl_r[SLP_FAST_BIT] && !run_bit
    |=> sleep_ack) else $error("fast sleep answer missing");
  slow_sleep_ack_a: assert property (
    !sleep_ctl_r[SLP_FAST_BIT] && !sleep_ready |=> !sleep_ack)
    else $error("sleep answer ignored ready");
  lock_select_a: assert property (
    !sleep_ctl_r[SLP_LOCK_BIT] |=> pll_lock_indication
    == $past(pll_lock_logic)) else $error("lock source wrong");
  wake_gate_a: assert property (
    !sleep_ctl_r[0] |=> !port_wake_out[0])
    else $error("disabled port woke");
  flag_readonly_a: assert property (
    do_write && aw_idx_r == IDX_BIST |=> !bist_ctl_r[BIST_FLAG_BIT]
    && !bist_ctl_r[5]) else $error("read-only bit stored");
  trim_write_a: assert property (
    do_write && wen_r && aw_idx_r == IDX_TRIM_LO
    |=> phy_ctl.disc_trim[7:0] == $past(wbyte_r))
    else $error("trim not written");
  hs_reserved_a: assert property (
    hs_test_r[7:6] == 2'h0 && trim_hi_r[7:4] == 4'h0)
    else $error("reserved bits set");
  write_resp_a: assert property (
    do_write |=> s_axi_bvalid ##0 s_axi_bresp ==
    (is_mapped($past(aw_idx_r)) ? RESP_OKAY : RESP_SLVERR))
    else $error("write response wrong");
  read_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  irq_level_a: assert property (
    irq == |(int_sts_r & int_msk_r))
    else $error("irq without cause");

  fast_ack_c: cover property (sleep_req && !run_bit ##1 sleep_ack);
  write_c: cover property (do_write ##1 s_axi_bvalid);
  read_c: cover property (s_axi_rvalid && s_axi_rready);
  irq_c: cover property (!irq ##1 irq);

endmodule : upptc_regs

// ### testbench/upptc_pmu_model.sv
module upptc_pmu_model
  import upptc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic sleep_ack,
  output logic sleep_req,
  output logic acked
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n;
  // ------------------------------
  // request held until answered or wait_n reaches 12
  // ------------------------------
  // a real unit gives up after a while, so the model does too
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_req <= 1'b0;
      acked <= 1'b0;
      wait_n <= 0;
    end
    else if (!sleep_req)
    begin
      wait_n <= 0;
      if (go)
      begin
        sleep_req <= 1'b1;
        acked <= 1'b0;
      end
    end
    else if (sleep_ack || wait_n == 12)
    begin
      sleep_req <= 1'b0;
      acked <= sleep_ack;
    end
    else
      wait_n <= wait_n + 1;
  end
endmodule : upptc_pmu_model

// ### testbench/usb_phy_power_test_control_bench.sv
module usb_phy_power_test_control_bench
  import upptc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, go, acked, irq, bist_match;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic sleep_req, run_bit, dev_connected, sleep_ready, sleep_ack;
  logic lk_c, lk_l, lk_o;
  logic [NPORT-1:0] wake_in, wake_out;
  upptc_phy_ctl_t phy_ctl;
  logic [7:0] sh [5];
  logic [7:0] d;
  localparam logic [9:0] IDX [5] = '{IDX_SLEEP, IDX_BIST, IDX_TRIM_LO,
    IDX_TRIM_HI, IDX_HS_TEST};
  localparam logic [7:0] RST [5] = '{RST_SLEEP, RST_BIST, RST_TRIM_LO,
    RST_TRIM_HI, RST_HS_TEST};
  localparam logic [7:0] WM [5] = '{WMSK_SLEEP, WMSK_BIST, WMSK_TRIM_LO,
    WMSK_TRIM_HI, WMSK_HS_TEST};
  int n_fail = 0;
  int check_count = 0;

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  upptc_regs i_upptc_regs (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_req(sleep_req),
    .run_bit(run_bit), .dev_connected(dev_connected),
    .sleep_ready(sleep_ready), .sleep_ack(sleep_ack),
    .pll_lock_circuit(lk_c), .pll_lock_logic(lk_l),
    .pll_lock_indication(lk_o), .port_wake_evt(wake_in),
    .port_wake_out(wake_out), .bist_match(bist_match), .phy_ctl(phy_ctl),
    .irq(irq));

  upptc_pmu_model i_upptc_pmu_model (.aclk(aclk), .aresetn(aresetn),
    .go(go), .sleep_ack(sleep_ack), .sleep_req(sleep_req), .acked(acked));

  // ------------------------------
  // checking and closing
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict;
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // ------------------------------
  // bus master
  // ------------------------------
  // the master never assumes a latency; only the watchdog ends a hang
  task automatic wr(input logic [9:0] i, input logic [7:0] v,
    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
    for (int k = 0; k < 5; k++)
      if (IDX[k] == i)
        sh[k] = v & WM[k];
  endtask : wr

  task automatic rdc(input logic [9:0] i, input logic [7:0] e,
    input logic [1:0] er);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, {24'h0, e});
    chk("rresp", 32'(rresp), 32'(er));
  endtask : rdc

  task automatic chk_reg(input int k);
    rdc(IDX[k], (k == 1) ? (sh[1] | {3'h0, bist_match, 4'h0}) : sh[k],
      RESP_OKAY);
    chk("phy_ctl", 32'(phy_ctl), {8'h0, sh[1][7:6], sh[1][3], sh[1][2:0],
      sh[3][3:0], sh[2], sh[4][5:0]});
  endtask : chk_reg

  task automatic ask_sleep;
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (20) @(posedge aclk);
  endtask : ask_sleep

  // ------------------------------
  // watchdog
  // ------------------------------
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    give_verdict();
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    {aresetn, go, awvalid, wvalid, bready, arvalid, rready} = '0;
    {run_bit, dev_connected, sleep_ready, lk_c, lk_l, bist_match} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    wake_in = '0;
    void'($urandom(81924));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // all shadows first: every phy_ctl compare reads shadows 1 to 4
    for (int k = 0; k < 5; k++)
      sh[k] = RST[k];
    for (int k = 0; k < 5; k++)
      chk_reg(k);
    // lane 0 strobe low: answered, but nothing may change
    d = sh[2];
    wstrb <= 4'h0;
    wr(IDX_TRIM_LO, ~d, RESP_OKAY);
    sh[2] = d;
    wstrb <= 4'h1;
    chk_reg(2);
    wr(10'h070, 8'hFF, RESP_SLVERR);
    rdc(10'h070, 8'h00, RESP_SLVERR);
    for (int k = 0; k < 10; k++)
    begin
      d = 8'($urandom);
      wr(IDX[k / 2], d, RESP_OKAY);
      chk_reg(k / 2);
    end
    bist_match <= 1'b1;
    repeat (4) @(posedge aclk);
    chk_reg(1);
    for (int k = 0; k < 4; k++)
    begin
      lk_c <= k[0];
      lk_l <= ~k[0];
      wr(IDX_SLEEP, {1'b1, k[1], 6'h00}, RESP_OKAY);
      repeat (5) @(posedge aclk);
      chk("lock", 32'(lk_o), 32'(k[1] ? k[0] : !k[0]));
    end
    wake_in <= 6'h3F;
    for (int k = 0; k < 6; k++)
    begin
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'h3F : 8'($urandom);
      wr(IDX_SLEEP, {2'b11, d[5:0]}, RESP_OKAY);
      repeat (5) @(posedge aclk);
      chk("wake", 32'(wake_out), 32'(d[5:0]));
    end
    wake_in <= 6'h00;
    for (int k = 0; k < 9; k++)
    begin
      wr(IDX_SLEEP, {k[2], 7'h40}, RESP_OKAY);
      run_bit <= k[1];
      dev_connected <= k[0];
      sleep_ready <= (k == 8);
      ask_sleep();
      chk("sleep_ack", 32'(acked),
        32'((k == 8) || (k[2] && !(k[1] && k[0]))));
    end
    // interrupt: clear, mask, raise, mask off, clear
    sleep_ready <= 1'b0;
    wr(IDX_INT_STS, 8'hFF, RESP_OKAY);
    rdc(IDX_INT_STS, 8'h00, RESP_OKAY);
    wr(IDX_INT_MSK, 8'h02, RESP_OKAY);
    rdc(IDX_INT_MSK, 8'h02, RESP_OKAY);
    chk("irq", 32'(irq), 32'h0);
    wr(IDX_SLEEP, 8'hC0, RESP_OKAY);
    run_bit <= 1'b0;
    ask_sleep();
    chk("irq", 32'(irq), 32'h1);
    rdc(IDX_INT_STS, 8'h02, RESP_OKAY);
    wr(IDX_INT_MSK, 8'h00, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'(irq), 32'h0);
    wr(IDX_INT_STS, 8'h02, RESP_OKAY);
    rdc(IDX_INT_STS, 8'h00, RESP_OKAY);
    give_verdict();
  end
endmodule : usb_phy_power_test_control_bench
